// ### rtl/urct_timer.sv
// What this block does
// - Up overflow: flag, reload (zero in capture mode), keep counting
// - Trigger fall reloads counter, sets external flag
// - Decrement enable: pin picks direction
// - Down match reload: flag, load 0xffff
// - Select bit: reload clear, capture set
// - Run bit starts and stops counting
// - External flag toggles on wrap, reload mode
// - Overflow flag sticky, requests interrupt
// - External flag sticky on trigger event
// - External enable clear ignores trigger fall
// - Capture copies count on trigger fall
// - Counter select picks prescale or pin
// - Two-bit field selects timer clock
// - Toggle output inverts on every wrap
// - Toggle bit reads level, write forces
// - Output enable gates toggle onto pin
// - Square wave period from reload value
// - Reload pair holds capture or reload
// - Counter readable as two bytes
`timescale 1ns/10ps
`include "urct_defs.svh"
module urct_timer
  import urct_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  // Pins
  input wire logic countPinIn,
  input wire logic extOscIn,
  input wire logic trigPinIn,
  output logic togglePinOut,
  output logic togglePinOe_n,
  // Interrupt request
  output logic timerIrqReq
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic ovfFlag, extFlag, extEn, runCtl, ctSel, cpSel;
  urct_clk_e clkMode;
  logic togState, outEn, decEn;
  urct_count_t count, reload;
  logic next_ovfFlag, next_extFlag, next_extEn, next_runCtl, next_ctSel, next_cpSel;
  urct_clk_e next_clkMode;
  logic next_togState, next_outEn, next_decEn;
  urct_count_t next_count, next_reload;
  logic [7:0] next_regRdData;
  logic cntTick, upDir, trigAct, wrapEvt;
  logic wrCtl, wrCfg, wrRl, wrRh, wrCl, wrCh;
  logic extReq, next_extReq;

  urct_tick_if tickBus ();

  urct_tick_gen u_tick (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .countPinIn(countPinIn),
    .extOscIn(extOscIn),
    .trigPinIn(trigPinIn),
    .clockMode(clkMode),
    .counterSelect(ctSel),
    .tickBus(tickBus)
  );

  // ----------------------------------------
  // Count engine and registers
  // ----------------------------------------
  always_comb begin
    wrCtl = regWrEn && regAddr == `URCT_ADDR_CTRL;
    wrCfg = regWrEn && regAddr == `URCT_ADDR_CFG;
    wrRl = regWrEn && regAddr == `URCT_ADDR_RCAP_LO;
    wrRh = regWrEn && regAddr == `URCT_ADDR_RCAP_HI;
    wrCl = regWrEn && regAddr == `URCT_ADDR_CNT_LO;
    wrCh = regWrEn && regAddr == `URCT_ADDR_CNT_HI;
    cntTick = runCtl & tickBus.countTick;
    upDir = ~decEn | tickBus.trigLevel;
    trigAct = tickBus.trigFall & extEn & ~decEn;
    wrapEvt = 1'b0;
    next_ovfFlag = wrCtl ? regWrData[`URCT_CTL_OVF] : ovfFlag;
    next_extFlag = wrCtl ? regWrData[`URCT_CTL_EXF] : extFlag;
    next_extEn = wrCtl ? regWrData[`URCT_CTL_EXEN] : extEn;
    next_runCtl = wrCtl ? regWrData[`URCT_CTL_RUN] : runCtl;
    next_ctSel = wrCtl ? regWrData[`URCT_CTL_CTS] : ctSel;
    next_cpSel = wrCtl ? regWrData[`URCT_CTL_CPS] : cpSel;
    next_clkMode = wrCfg ? urct_clk_e'(regWrData[`URCT_CFG_MODE_HI:`URCT_CFG_MODE_LO])
                         : clkMode;
    next_outEn = wrCfg ? regWrData[`URCT_CFG_OE] : outEn;
    next_decEn = wrCfg ? regWrData[`URCT_CFG_DECREMENT_ENABLE] : decEn;
    next_reload = reload;
    if (wrRl) begin
      next_reload[7:0] = regWrData;
    end
    if (wrRh) begin
      next_reload[15:8] = regWrData;
    end
    next_count = count;
    if (cntTick) begin
      if (upDir) begin
        next_count = count + 16'h0001;
        if (count == `URCT_CNT_TOP) begin
          wrapEvt = 1'b1;
          next_count = cpSel ? `URCT_CNT_BOTTOM : reload;
        end
      end else if (!cpSel && count == reload) begin
        wrapEvt = 1'b1;
        next_count = `URCT_CNT_TOP;
      end else begin
        next_count = count - 16'h0001;
        wrapEvt = cpSel && count == `URCT_CNT_BOTTOM;
      end
    end
    if (trigAct && !cpSel) begin
      next_count = reload;
    end
    if (wrCl) begin
      next_count[7:0] = regWrData;
    end
    if (wrCh) begin
      next_count[15:8] = regWrData;
    end
    if (trigAct && cpSel) begin
      next_reload = count;
    end
    if (wrapEvt && !cpSel) begin
      next_extFlag = ~next_extFlag;
    end
    if (trigAct) begin
      next_extFlag = 1'b1;
    end
    next_extReq = wrCtl ? (extReq & regWrData[`URCT_CTL_EXF]) : extReq;
    if (trigAct) begin
      next_extReq = 1'b1;
    end
    if (wrapEvt) begin
      next_ovfFlag = 1'b1;
    end
    next_togState = wrCfg ? regWrData[`URCT_CFG_TOG] : togState;
    if (wrapEvt) begin
      next_togState = ~next_togState;
    end
    next_regRdData = 8'h00;
    if (regRdEn) begin
      unique case (regAddr)
        `URCT_ADDR_CTRL: next_regRdData = {ovfFlag, extFlag, 2'b00, extEn, runCtl,
                                           ctSel, cpSel};
        `URCT_ADDR_CFG: next_regRdData = {3'b000, clkMode, togState, outEn, decEn};
        `URCT_ADDR_RCAP_LO: next_regRdData = reload[7:0];
        `URCT_ADDR_RCAP_HI: next_regRdData = reload[15:8];
        `URCT_ADDR_CNT_LO: next_regRdData = count[7:0];
        `URCT_ADDR_CNT_HI: next_regRdData = count[15:8];
        default: next_regRdData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ovfFlag <= 1'b0;
      extFlag <= 1'b0;
      extReq <= 1'b0;
      extEn <= 1'b0;
      runCtl <= 1'b0;
      ctSel <= 1'b0;
      cpSel <= 1'b0;
      clkMode <= URCT_CLK_DIV12;
      togState <= 1'b0;
      outEn <= 1'b0;
      decEn <= 1'b0;
      count <= `URCT_RST_WORD;
      reload <= `URCT_RST_WORD;
      regRdData <= `URCT_RST_BYTE;
    end else begin
      ovfFlag <= next_ovfFlag;
      extFlag <= next_extFlag;
      extReq <= next_extReq;
      extEn <= next_extEn;
      runCtl <= next_runCtl;
      ctSel <= next_ctSel;
      cpSel <= next_cpSel;
      clkMode <= next_clkMode;
      togState <= next_togState;
      outEn <= next_outEn;
      decEn <= next_decEn;
      count <= next_count;
      reload <= next_reload;
      regRdData <= next_regRdData;
    end
  end

  // ----------------------------------------
  // Pin and request outputs
  // ----------------------------------------
  // output enable gate
  assign togglePinOut = outEn & togState;
  assign togglePinOe_n = ~outEn;
  assign timerIrqReq = ovfFlag | extReq;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  logic quiet;
  assign quiet = !regWrEn;
  logic forcedTog;
  assign forcedTog = regWrData[`URCT_CFG_TOG];

  upOverflow_a: assert property (
    quiet && cntTick && upDir && !cpSel && !trigAct && count == `URCT_CNT_TOP
    |=> count == $past(reload) && ovfFlag)
    else $error("up overflow did not reload");
  downMatch_a: assert property (
    quiet && cntTick && !upDir && !cpSel && count == reload
    |=> count == `URCT_CNT_TOP && ovfFlag)
    else $error("down match did not load top");
  trigReload_a: assert property (
    quiet && trigAct && !cpSel |=> count == $past(reload) && extFlag)
    else $error("trigger reload missing");
  capture_a: assert property (
    quiet && trigAct && cpSel |=> reload == $past(count) && extFlag)
    else $error("capture missing");
  stoppedHold_a: assert property (
    quiet && !runCtl && !trigAct |=> count == $past(count))
    else $error("counter moved while stopped");
  extToggle_a: assert property (
    quiet && wrapEvt && !cpSel && !trigAct |=> extFlag != $past(extFlag))
    else $error("external flag did not toggle");
  ovfSticky_a: assert property (
    ovfFlag && !wrCtl |=> ovfFlag)
    else $error("overflow flag dropped");
  ignoreTrig_a: assert property (
    quiet && !extEn && !cpSel && !cntTick |=> count == $past(count))
    else $error("trigger acted while disabled");
  togWrap_a: assert property (
    quiet && wrapEvt |=> togState != $past(togState))
    else $error("toggle missed a wrap");
  pinGate_a: assert property (
    !outEn |-> !togglePinOut && togglePinOe_n)
    else $error("toggle reached pin while disabled");
  upOnly_a: assert property (
    quiet && !decEn && cntTick && !trigAct && count != `URCT_CNT_TOP
    |=> count == $past(count) + 16'h0001)
    else $error("count did not advance up");
  ovfSet_a: assert property (
    wrapEvt |=> ovfFlag)
    else $error("overflow flag not set on wrap");
  capWrap_a: assert property (
    quiet && cntTick && !upDir && cpSel && count == `URCT_CNT_BOTTOM
    |=> count == `URCT_CNT_TOP && ovfFlag)
    else $error("capture underflow missed");
  downStep_a: assert property (
    quiet && cntTick && !upDir && count != reload |=> count == $past(count) - 16'h0001)
    else $error("count did not step down");
  extSticky_a: assert property (
    extFlag && !wrCtl && !(wrapEvt && !cpSel) |=> extFlag)
    else $error("external flag dropped");
  extQuiet_a: assert property (
    !trigAct && !extReq && !wrCtl |=> timerIrqReq == ovfFlag)
    else $error("wrap toggle requested service");
  togForce_a: assert property (
    wrCfg && !wrapEvt |=> togState == $past(forcedTog))
    else $error("toggle level not forced");
  cntHigh_a: assert property (
    wrCh |=> count[15:8] == $past(regWrData))
    else $error("count high byte write lost");
  cntLow_a: assert property (
    wrCl |=> count[7:0] == $past(regWrData))
    else $error("count low byte write lost");
  rsvdRead_a: assert property (
    regRdEn && regAddr == `URCT_ADDR_CTRL |=> regRdData[5:4] == 2'b00)
    else $error("reserved control bits read set");
  pinFollow_a: assert property (
    outEn |-> togglePinOut == togState && !togglePinOe_n)
    else $error("toggle missing from pin");

  // ----------------------------------------
  // Cover points
  // ----------------------------------------
  upWrapCov: cover property (cntTick && upDir && count == `URCT_CNT_TOP);
  downWrapCov: cover property (cntTick && !upDir && !cpSel && count == reload);
  captureCov: cover property (trigAct && cpSel);
  trigReloadCov: cover property (trigAct && !cpSel);
  togPinCov: cover property (wrapEvt && outEn);

endmodule

// ### rtl/urct_defs.svh
`ifndef URCT_DEFS_SVH
`define URCT_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define URCT_ADDR_CTRL 8'hc8
`define URCT_ADDR_CFG 8'hc9
`define URCT_ADDR_RCAP_LO 8'hca
`define URCT_ADDR_RCAP_HI 8'hcb
`define URCT_ADDR_CNT_LO 8'hcc
`define URCT_ADDR_CNT_HI 8'hcd

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define URCT_CTL_OVF 7
`define URCT_CTL_EXF 6
`define URCT_CTL_EXEN 3
`define URCT_CTL_RUN 2
`define URCT_CTL_CTS 1
`define URCT_CTL_CPS 0

// ----------------------------------------
// Configuration field positions
// ----------------------------------------
`define URCT_CFG_MODE_HI 4
`define URCT_CFG_MODE_LO 3
`define URCT_CFG_TOG 2
`define URCT_CFG_OE 1
`define URCT_CFG_DECREMENT_ENABLE 0

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define URCT_RST_BYTE 8'h00
`define URCT_RST_WORD 16'h0000
`define URCT_CNT_TOP 16'hffff
`define URCT_CNT_BOTTOM 16'h0000
`define URCT_DIV12_LAST 4'hb
`define URCT_DIV2_LAST 4'h1
`define URCT_EXT8_LAST 4'h7
`define URCT_SYS_LAST 4'h0

`endif

// ### rtl/urct_pkg.sv
package urct_pkg;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    URCT_CLK_DIV12 = 2'b00,
    URCT_CLK_SYS = 2'b01,
    URCT_CLK_EXT8 = 2'b10,
    URCT_CLK_DIV2 = 2'b11
  } urct_clk_e;

  typedef logic [15:0] urct_count_t;

endpackage

// ### rtl/urct_tick_if.sv
`timescale 1ns/10ps
interface urct_tick_if;
  logic countTick;
  logic trigFall;
  logic trigLevel;
  modport src (output countTick, output trigFall, output trigLevel);
  modport sink (input countTick, input trigFall, input trigLevel);
endinterface

// ### rtl/urct_tick_gen.sv
`timescale 1ns/10ps
`include "urct_defs.svh"
module urct_tick_gen
  import urct_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Pins
  input wire logic countPinIn,
  input wire logic extOscIn,
  input wire logic trigPinIn,
  // Setup
  input urct_clk_e clockMode,
  input wire logic counterSelect,
  // Events
  urct_tick_if.src tickBus
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0] syncA, syncB, prevS;
  logic [2:0] next_syncA, next_syncB, next_prevS;
  logic [3:0] preCnt, next_preCnt;
  logic [2:0] fall;
  logic step, atLast;

  function automatic logic [3:0] divLast(urct_clk_e m);
    unique case (m)
      URCT_CLK_DIV12: divLast = `URCT_DIV12_LAST;
      URCT_CLK_SYS: divLast = `URCT_SYS_LAST;
      URCT_CLK_EXT8: divLast = `URCT_EXT8_LAST;
      URCT_CLK_DIV2: divLast = `URCT_DIV2_LAST;
    endcase
  endfunction

  always_comb begin
    next_syncA = {trigPinIn, extOscIn, countPinIn};
    next_syncB = syncA;
    next_prevS = syncB;
    fall = prevS & ~syncB;
    step = (clockMode == URCT_CLK_EXT8) ? fall[1] : 1'b1;
    atLast = preCnt >= divLast(clockMode);
    next_preCnt = preCnt;
    if (step) begin
      next_preCnt = atLast ? 4'h0 : preCnt + 4'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA <= 3'h0;
      syncB <= 3'h0;
      prevS <= 3'h0;
      preCnt <= 4'h0;
    end else begin
      syncA <= next_syncA;
      syncB <= next_syncB;
      prevS <= next_prevS;
      preCnt <= next_preCnt;
    end
  end

  // ----------------------------------------
  // Event outputs
  // ----------------------------------------
  // counter or timer source
  assign tickBus.countTick = counterSelect ? fall[0] : (step & atLast);
  assign tickBus.trigFall = fall[2];
  assign tickBus.trigLevel = syncB[2];

endmodule

// ### verif/tb_updown_reload_capture_timer.sv
`timescale 1ns/10ps
`include "urct_defs.svh"
module tb_updown_reload_capture_timer import urct_pkg::*;;
  // ----------------------------------------
  // Stimulus and design
  // ----------------------------------------
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [7:0] regWrData = 8'h00;
  logic [7:0] regRdData;
  logic countPinIn = 1'b1;
  logic extOscIn = 1'b0;
  logic trigPinIn = 1'b1;
  logic togglePinOut;
  logic togglePinOe_n;
  logic timerIrqReq;
  logic [1:0] extDiv = 2'h0;
  int n_errors = 0;
  int tests_run = 0;

  always #4 core_clk = ~core_clk;

  // External clock, falling edge every 4 cycles
  always @(posedge core_clk) begin
    extDiv <= extDiv + 2'h1;
    extOscIn <= extDiv[1];
  end

  urct_timer urct_timer_inst (.core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData),
    .countPinIn(countPinIn), .extOscIn(extOscIn), .trigPinIn(trigPinIn),
    .togglePinOut(togglePinOut), .togglePinOe_n(togglePinOe_n), .timerIrqReq(timerIrqReq));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge core_clk);
    regWrEn <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge core_clk);
    regRdEn <= 1'b0;
    #1;
    d = regRdData;
  endtask

  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 8'h01, v[15:8]);
  endtask

  task automatic rd16(input logic [7:0] a, output logic [15:0] v);
    logic [7:0] lo;
    logic [7:0] hi;
    rd(a, lo);
    rd(a + 8'h01, hi);
    v = {hi, lo};
  endtask

  task automatic pulse(input bit trig);
    @(posedge core_clk);
    if (trig) trigPinIn <= 1'b0;
    else countPinIn <= 1'b0;
    repeat (3) @(posedge core_clk);
    if (trig) trigPinIn <= 1'b1;
    else countPinIn <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask

  task automatic setTrig(input logic lvl);
    @(posedge core_clk);
    trigPinIn <= lvl;
    repeat (4) @(posedge core_clk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [7:0] d;
    for (int i = 0; i < 6; i++) begin
      rd(`URCT_ADDR_CTRL + i[7:0], d);
      chk("reset value", d, 16'h0000);
    end
    rd(8'hce, d);
    chk("unmapped read", d, 16'h0000);
    chk("oe idle", togglePinOe_n, 16'h0001);
    chk("pin idle", togglePinOut, 16'h0000);
    chk("irq idle", timerIrqReq, 16'h0000);
    wr(`URCT_ADDR_CTRL, 8'h30);
    rd(`URCT_ADDR_CTRL, d);
    chk("ctrl reserved", d, 16'h0000);
    wr(`URCT_ADDR_CFG, 8'he0);
    rd(`URCT_ADDR_CFG, d);
    chk("cfg reserved", d, 16'h0000);
    $display("done reset");
  endtask

  task automatic t_up_wrap();
    logic [7:0] d;
    logic [15:0] v;
    wr(`URCT_ADDR_CFG, 8'h02);
    wr16(`URCT_ADDR_RCAP_LO, 16'h1234);
    wr16(`URCT_ADDR_CNT_LO, 16'hffff);
    wr(`URCT_ADDR_CTRL, 8'h06);
    pulse(0);
    rd16(`URCT_ADDR_CNT_LO, v);
    chk("up reload", v, 16'h1234);
    rd(`URCT_ADDR_CTRL, d);
    chk("up flags", d, 16'h00c6);
    chk("irq up", timerIrqReq, 16'h0001);
    rd(`URCT_ADDR_CFG, d);
    chk("toggle bit", d, 16'h0006);
    chk("pin level", togglePinOut, 16'h0001);
    chk("pin driven", togglePinOe_n, 16'h0000);
    pulse(0);
    rd16(`URCT_ADDR_CNT_LO, v);
    chk("pin count", v, 16'h1235);
    rd(`URCT_ADDR_CTRL, d);
    chk("flags sticky", d, 16'h00c6);
    wr(`URCT_ADDR_CTRL, 8'h46);
    rd(`URCT_ADDR_CTRL, d);
    chk("ovf cleared", d, 16'h0046);
    chk("ext no irq", timerIrqReq, 16'h0000);
    $display("done up wrap");
  endtask

  task automatic t_down();
    logic [7:0] d;
    logic [15:0] v;
    wr(`URCT_ADDR_CTRL, 8'h00);
    wr(`URCT_ADDR_CFG, 8'h01);
    setTrig(1'b0);
    wr16(`URCT_ADDR_RCAP_LO, 16'h0010);
    wr16(`URCT_ADDR_CNT_LO, 16'h0011);
    wr(`URCT_ADDR_CTRL, 8'h0e);
    pulse(0);
    rd16(`URCT_ADDR_CNT_LO, v);
    chk("down step", v, 16'h0010);
    pulse(0);
    rd16(`URCT_ADDR_CNT_LO, v);
    chk("down match", v, 16'hffff);
    rd(`URCT_ADDR_CTRL, d);
    chk("down flags", d, 16'h00ce);
    rd(`URCT_ADDR_CFG, d);
    chk("toggle down", d, 16'h0005);
    chk("pin gated", togglePinOut, 16'h0000);
    setTrig(1'b1);
    pulse(0);
    rd16(`URCT_ADDR_CNT_LO, v);
    chk("dir up", v, 16'h0010);
    rd(`URCT_ADDR_CTRL, d);
    chk("ext back", d, 16'h008e);
    wr(`URCT_ADDR_CTRL, 8'h02);
    pulse(0);
    rd16(`URCT_ADDR_CNT_LO, v);
    chk("run off", v, 16'h0010);
    $display("done down");
  endtask

  task automatic t_trig();
    logic [7:0] d;
    logic [15:0] v;
    wr(`URCT_ADDR_CTRL, 8'h00);
    wr(`URCT_ADDR_CFG, 8'h00);
    wr16(`URCT_ADDR_RCAP_LO, 16'h1234);
    wr16(`URCT_ADDR_CNT_LO, 16'h5555);
    pulse(1);
    rd16(`URCT_ADDR_CNT_LO, v);
    chk("trig ignored", v, 16'h5555);
    wr(`URCT_ADDR_CTRL, 8'h08);
    pulse(1);
    rd16(`URCT_ADDR_CNT_LO, v);
    chk("trig reload", v, 16'h1234);
    rd(`URCT_ADDR_CTRL, d);
    chk("ext set", d, 16'h0048);
    chk("irq ext", timerIrqReq, 16'h0001);
    wr(`URCT_ADDR_CTRL, 8'h09);
    wr16(`URCT_ADDR_CNT_LO, 16'habcd);
    pulse(1);
    rd16(`URCT_ADDR_RCAP_LO, v);
    chk("capture", v, 16'habcd);
    rd16(`URCT_ADDR_CNT_LO, v);
    chk("count kept", v, 16'habcd);
    wr(`URCT_ADDR_CFG, 8'h01);
    setTrig(1'b0);
    wr16(`URCT_ADDR_CNT_LO, 16'h0000);
    wr(`URCT_ADDR_CTRL, 8'h07);
    pulse(0);
    rd16(`URCT_ADDR_CNT_LO, v);
    chk("cap underflow", v, 16'hffff);
    rd(`URCT_ADDR_CTRL, d);
    chk("cap flags", d, 16'h0087);
    setTrig(1'b1);
    $display("done trigger");
  endtask

  task automatic t_clocks();
    int expc[4] = '{21, 256, 8, 128};
    int n;
    logic [15:0] v;
    logic p;
    for (int m = 0; m < 4; m++) begin
      wr(`URCT_ADDR_CTRL, 8'h00);
      wr(`URCT_ADDR_CFG, {3'h0, m[1:0], 3'h0});
      wr16(`URCT_ADDR_CNT_LO, 16'h0000);
      wr(`URCT_ADDR_CTRL, 8'h04);
      repeat (254) @(posedge core_clk);
      wr(`URCT_ADDR_CTRL, 8'h00);
      rd16(`URCT_ADDR_CNT_LO, v);
      chk("prescale", (v + 2 >= expc[m]) && (v <= expc[m] + 2), 16'h0001);
    end
    wr(`URCT_ADDR_CFG, 8'h0a);
    wr16(`URCT_ADDR_RCAP_LO, 16'hfff0);
    wr16(`URCT_ADDR_CNT_LO, 16'hfff0);
    wr(`URCT_ADDR_CTRL, 8'h04);
    p = togglePinOut;
    for (n = 0; n < 40 && togglePinOut === p; n++) begin
      @(posedge core_clk);
      #1;
    end
    chk("first toggle", n < 40, 16'h0001);
    p = togglePinOut;
    for (n = 0; n < 40 && togglePinOut === p; n++) begin
      @(posedge core_clk);
      #1;
    end
    chk("half period", n[15:0], 16'h0010);
    $display("done clocks");
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    #200000;
    n_errors++;
    $display("BAD watchdog expected end seen hang");
    test_done();
  end

  initial begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_up_wrap();
    t_down();
    t_trig();
    t_clocks();
    test_done();
  end
endmodule
